// File: hw/bus_controller_codec.sv
// The implementer's own choices: the strobed register port and the register offsets.
`timescale 1ns/10ps
module bus_controller_codec (
  // clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     rst,
  // software register port
  input  wire logic [codec_pkg::RA_W-1:0] reg_addr,
  input  wire logic [31:0]              reg_wr_data,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic      [31:0]              reg_rd_data,
  // serial bus
  input  wire logic                     bus_rx,
  output logic                          bus_tx,
  output logic                          bus_tx_oe
);
  import codec_pkg::*;

  // command fields taken from a write
  logic [4:0]  wr_taddr;
  logic        wr_tr;
  logic [4:0]  wr_sa;
  logic [4:0]  wr_wc;
  logic        wr_mode;
  logic        wr_cmd;
  logic        wr_data;
  logic        rd_stat;
  logic        rd_rx;

  // transmit state
  logic [15:0] tx_info;
  logic        tx_par;
  logic [16:0] tx_bits;
  logic [33:0] man_bits;
  logic [39:0] pat_ff;
  logic [5:0]  halves_ff;
  logic [9:0]  htmr_ff;
  logic        busy_ff;

  // last command sent
  logic [4:0]  last_addr_ff;
  logic        bcast_ff;
  logic        mode_ff;
  logic        resp_exp_ff;
  logic [5:0]  exp_words_ff;
  logic [5:0]  nxt_exp_words;

  // software-visible flags
  logic        refused_ff;
  logic        rx_valid_ff;
  logic        rx_err_ff;
  logic        rx_cmd_ff;
  logic        overrun_ff;
  logic        addr_mism_ff;
  logic [15:0] rx_word_ff;
  logic [5:0]  rx_cnt_ff;
  logic [31:0] rd_data_ff;
  logic [31:0] stat_word;

  rx_word_if rxw ();

  word_decoder u_dec (
    .clk_sys (clk_sys),
    .rst     (rst),
    .bus_rx  (bus_rx),
    .rx      (rxw)
  );

  // the controller does not listen to its own transmission
  assign rxw.listen = !busy_ff;

  // ---- decode of the software strobes

  assign wr_cmd  = reg_wr && reg_addr == REG_CMD;
  assign wr_data = reg_wr && reg_addr == REG_DATA;
  assign rd_stat = reg_rd && reg_addr == REG_STAT;
  assign rd_rx   = reg_rd && reg_addr == REG_RX;

  assign wr_taddr = reg_wr_data[WR_ADDR_LSB +: FIELD_W];
  assign wr_tr    = reg_wr_data[WR_TR_BIT];
  assign wr_sa    = reg_wr_data[WR_SA_LSB +: FIELD_W];
  assign wr_wc    = reg_wr_data[WR_WC_LSB +: FIELD_W];
  assign wr_mode  = wr_sa == SA_MODE_LO || wr_sa == SA_MODE_HI;

  // ---- word assembly

  always_comb begin
    tx_info = '0; // bits not loaded below go out as zero
    if (wr_cmd) begin
      tx_info[ADDR_LSB +: FIELD_W] = wr_taddr;
      tx_info[TR_BIT]              = wr_tr;
      tx_info[SA_LSB +: FIELD_W]   = wr_sa;
      tx_info[WC_LSB +: FIELD_W]   = wr_wc;
    end else begin
      tx_info = reg_wr_data[INFO_W-1:0];
    end
  end

  assign tx_par  = ~(^tx_info);
  assign tx_bits = {tx_info, tx_par};

  // each bit becomes two halves, value first then its inverse
  genvar gi;
  generate
    for (gi = 0; gi < 17; gi++) begin : g_man
      assign man_bits[2*gi+1] = tx_bits[gi];
      assign man_bits[2*gi]   = ~tx_bits[gi];
    end
  endgenerate

  // ---- transmitter

  // a write while a word is still on the line is dropped and flagged
  // words leave in the order written; software sends the most significant first
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      busy_ff   <= 1'b0;
      pat_ff    <= '0;
      halves_ff <= '0;
      htmr_ff   <= '0;
    end else if (!busy_ff && (wr_cmd || wr_data)) begin
      busy_ff   <= 1'b1;
      // most significant half goes out first
      pat_ff    <= {wr_cmd ? SYNC_CMD_PAT : SYNC_DATA_PAT, man_bits};
      halves_ff <= WORD_HALVES;
      htmr_ff   <= '0;
    end else if (busy_ff) begin
      if (htmr_ff == HALF_CYC - 10'h001) begin // fixed divide of clk_sys
        htmr_ff   <= '0;
        pat_ff    <= {pat_ff[38:0], 1'b0};
        halves_ff <= halves_ff - 6'h01;
        if (halves_ff == 6'h01) busy_ff <= 1'b0;
      end else begin
        htmr_ff <= htmr_ff + 10'h001;
      end
    end
  end

  assign bus_tx    = busy_ff && pat_ff[39];
  assign bus_tx_oe = busy_ff;

  always_ff @(posedge clk_sys) begin
    if (rst) refused_ff <= 1'b0;
    else if (busy_ff && (wr_cmd || wr_data)) refused_ff <= 1'b1;
    else if (rd_stat) refused_ff <= 1'b0;
  end

  // ---- bookkeeping of the last command sent

  always_comb begin
    if (wr_mode) nxt_exp_words = wr_wc[MODE_DATA_BIT] ? ONE_WORD : 6'h00;
    else if (wr_wc == WC_ZERO) nxt_exp_words = MAX_WORDS;
    else nxt_exp_words = {1'b0, wr_wc};
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      last_addr_ff <= '0;
      bcast_ff     <= 1'b0;
      mode_ff      <= 1'b0;
      resp_exp_ff  <= 1'b0;
      exp_words_ff <= '0;
    end else if (wr_cmd && !busy_ff) begin
      last_addr_ff <= wr_taddr;
      bcast_ff     <= wr_taddr == BCAST_ADDR;
      mode_ff      <= wr_mode;
      // no status answer follows a broadcast
      resp_exp_ff  <= wr_taddr != BCAST_ADDR;
      exp_words_ff <= nxt_exp_words;
    end
  end

  // ---- receive side

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rx_word_ff <= '0;
      rx_err_ff  <= 1'b0;
      rx_cmd_ff  <= 1'b0;
    end else if (rxw.valid) begin
      rx_word_ff <= rxw.word;
      rx_err_ff  <= rxw.err;
      rx_cmd_ff  <= rxw.cmd_sync; // status words arrive with command sync
    end
  end

  // new word wins over the clearing read
  always_ff @(posedge clk_sys) begin
    if (rst) rx_valid_ff <= 1'b0;
    else if (rxw.valid) rx_valid_ff <= 1'b1;
    else if (rd_rx) rx_valid_ff <= 1'b0;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) overrun_ff <= 1'b0;
    else if (rxw.valid && rx_valid_ff && !rd_rx) overrun_ff <= 1'b1;
    else if (rd_stat) overrun_ff <= 1'b0;
  end

  // status word must carry the address of the terminal just commanded
  always_ff @(posedge clk_sys) begin
    if (rst) addr_mism_ff <= 1'b0;
    else if (rxw.valid && rxw.cmd_sync && !rxw.err &&
             rxw.word[ADDR_LSB +: FIELD_W] != last_addr_ff) addr_mism_ff <= 1'b1;
    else if (rd_stat) addr_mism_ff <= 1'b0;
  end

  // data words counted since the last command
  always_ff @(posedge clk_sys) begin
    if (rst || (wr_cmd && !busy_ff)) rx_cnt_ff <= '0;
    else if (rxw.valid && !rxw.cmd_sync && rx_cnt_ff != MAX_WORDS) rx_cnt_ff <= rx_cnt_ff + 6'h01;
  end

  // ---- read port

  always_comb begin
    stat_word                            = '0;
    stat_word[ST_BUSY]                   = busy_ff;
    stat_word[ST_RX_VALID]               = rx_valid_ff;
    stat_word[ST_RX_ERR]                 = rx_err_ff;
    stat_word[ST_RX_CMD]                 = rx_cmd_ff;
    stat_word[ST_REFUSED]                = refused_ff;
    stat_word[ST_BCAST]                  = bcast_ff;
    stat_word[ST_MODE]                   = mode_ff;
    stat_word[ST_RESP_EXP]               = resp_exp_ff;
    stat_word[ST_EXP_LSB +: 6]           = exp_words_ff;
    stat_word[ST_OVERRUN]                = overrun_ff;
    stat_word[ST_ADDR_MISM]              = addr_mism_ff;
    stat_word[ST_RXCNT_LSB +: 6]         = rx_cnt_ff;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) rd_data_ff <= '0;
    else if (rd_stat) rd_data_ff <= stat_word;
    else if (rd_rx) rd_data_ff <= {16'h0000, rx_word_ff};
    else rd_data_ff <= '0;
  end

  assign reg_rd_data = rd_data_ff;
endmodule : bus_controller_codec

// File: hw/codec_pkg.sv
package codec_pkg;
  // timing
  localparam int         CLK_PERIOD_NS = 5;
  localparam int         BIT_TIME_NS   = 1000;
  localparam int         BIT_CYC_I     = BIT_TIME_NS / CLK_PERIOD_NS;
  localparam logic [9:0] BIT_CYC       = 10'(BIT_CYC_I);
  localparam logic [9:0] HALF_CYC      = 10'(BIT_CYC_I / 2);
  localparam logic [9:0] QTR_CYC       = 10'(BIT_CYC_I / 4);
  localparam logic [9:0] SYNC_RUN      = 10'(3 * BIT_CYC_I / 2);
  localparam logic [9:0] SYNC_MIN      = 10'(3 * BIT_CYC_I / 2 - BIT_CYC_I / 4);
  localparam logic [9:0] SYNC_MAX      = 10'(3 * BIT_CYC_I / 2 + BIT_CYC_I / 4);
  localparam logic [9:0] SYNC_CHK      = 10'(3 * BIT_CYC_I / 4);
  localparam logic [9:0] RUN_SAT       = 10'h3ff;
  // word layout
  localparam int         INFO_W        = 16;
  localparam logic [4:0] WORD_BITS     = 5'h11;
  localparam logic [5:0] WORD_HALVES   = 6'h28;
  localparam logic [5:0] SYNC_CMD_PAT  = 6'h38;
  localparam logic [5:0] SYNC_DATA_PAT = 6'h07;
  localparam int         ADDR_LSB      = 11;
  localparam int         TR_BIT        = 10;
  localparam int         SA_LSB        = 5;
  localparam int         WC_LSB        = 0;
  localparam int         FIELD_W       = 5;
  localparam logic [4:0] BCAST_ADDR    = 5'h1f;
  localparam logic [4:0] SA_MODE_LO    = 5'h00;
  localparam logic [4:0] SA_MODE_HI    = 5'h1f;
  localparam logic [4:0] WC_ZERO       = 5'h00;
  localparam logic [5:0] MAX_WORDS     = 6'h20;
  localparam logic [5:0] ONE_WORD      = 6'h01;
  localparam int         MODE_DATA_BIT = 4;
  // software registers
  localparam int         RA_W          = 8;
  localparam logic [7:0] REG_CMD       = 8'h00;
  localparam logic [7:0] REG_DATA      = 8'h04;
  localparam logic [7:0] REG_STAT      = 8'h08;
  localparam logic [7:0] REG_RX        = 8'h0c;
  localparam int         WR_ADDR_LSB   = 0;
  localparam int         WR_TR_BIT     = 8;
  localparam int         WR_SA_LSB     = 16;
  localparam int         WR_WC_LSB     = 24;
  localparam int         ST_BUSY       = 0;
  localparam int         ST_RX_VALID   = 1;
  localparam int         ST_RX_ERR     = 2;
  localparam int         ST_RX_CMD     = 3;
  localparam int         ST_REFUSED    = 4;
  localparam int         ST_BCAST      = 5;
  localparam int         ST_MODE       = 6;
  localparam int         ST_RESP_EXP   = 7;
  localparam int         ST_EXP_LSB    = 8;
  localparam int         ST_OVERRUN    = 14;
  localparam int         ST_ADDR_MISM  = 15;
  localparam int         ST_RXCNT_LSB  = 16;

  typedef enum {RX_HUNT, RX_SYNC, RX_BITS} rx_state_t;
endpackage : codec_pkg

// File: hw/rx_word_if.sv
`timescale 1ns/10ps
interface rx_word_if;
  logic        listen;
  logic        valid;
  logic [15:0] word;
  logic        cmd_sync;
  logic        err;

  modport dec (input listen, output valid, output word, output cmd_sync, output err);
  modport ctl (output listen, input valid, input word, input cmd_sync, input err);
endinterface : rx_word_if

// File: hw/word_decoder.sv
`timescale 1ns/10ps
module word_decoder (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // line
  input  wire logic bus_rx,
  // decoded words
  rx_word_if.dec    rx
);
  import codec_pkg::*;

  logic        meta_ff, lvl_ff, prev_ff, h1_ff, pol_ff, err_ff, valid_ff;
  logic [9:0]  run_ff, tmr_ff;
  logic [4:0]  cnt_ff;
  logic [16:0] sh_ff;
  rx_state_t   st_ff;

  always_ff @(posedge clk_sys) begin
    meta_ff <= bus_rx;
    lvl_ff  <= meta_ff;
    prev_ff <= lvl_ff;
  end

  // length of the current constant-level run
  always_ff @(posedge clk_sys) begin
    if (rst || lvl_ff != prev_ff) run_ff <= '0;
    else if (run_ff != RUN_SAT) run_ff <= run_ff + 10'h001;
  end

  always_ff @(posedge clk_sys) begin
    valid_ff <= 1'b0;
    if (rst || !rx.listen) begin
      st_ff  <= RX_HUNT;
      tmr_ff <= '0;
      cnt_ff <= '0;
      err_ff <= 1'b0;
      pol_ff <= 1'b0;
      h1_ff  <= 1'b0;
      sh_ff  <= '0;
    end else begin
      case (st_ff)
        RX_HUNT: if (lvl_ff != prev_ff && run_ff >= SYNC_MIN && run_ff <= SYNC_MAX) begin
          pol_ff <= prev_ff; // high first: command or status sync
          tmr_ff <= '0;
          cnt_ff <= '0;
          err_ff <= 1'b0;
          st_ff  <= RX_SYNC;
        end
        RX_SYNC: begin
          tmr_ff <= tmr_ff + 10'h001;
          if (tmr_ff == SYNC_CHK && lvl_ff == pol_ff) err_ff <= 1'b1;
          // the trailing part is sampled only once, halfway through it
          if (tmr_ff == SYNC_RUN - 10'h001) begin
            tmr_ff <= '0;
            st_ff  <= RX_BITS;
          end
        end
        RX_BITS: begin
          tmr_ff <= (tmr_ff == BIT_CYC - 10'h001) ? 10'h000 : tmr_ff + 10'h001;
          if (tmr_ff == QTR_CYC) h1_ff <= lvl_ff;
          if (tmr_ff == HALF_CYC + QTR_CYC) begin
            sh_ff  <= {sh_ff[15:0], h1_ff}; // first half carries the value
            cnt_ff <= cnt_ff + 5'h01;
            if (h1_ff == lvl_ff) err_ff <= 1'b1; // no mid-bit transition
            if (cnt_ff == WORD_BITS - 5'h01) begin
              valid_ff <= 1'b1;
              st_ff    <= RX_HUNT;
            end
          end
        end
        default: st_ff <= RX_HUNT;
      endcase
    end
  end

  assign rx.valid    = valid_ff;
  assign rx.word     = sh_ff[16:1];
  assign rx.cmd_sync = pol_ff;
  assign rx.err      = err_ff || !(^sh_ff); // odd parity over all 17 bits
endmodule : word_decoder

// File: tb/bus_controller_codec_monitor.sv
`timescale 1ns/10ps
module bus_controller_codec_monitor (
  // clock and reset
  input wire logic                         clk_sys,
  input wire logic                         rst,
  // register port
  input wire logic [codec_pkg::RA_W-1:0] reg_addr,
  input wire logic                         reg_wr,
  input wire logic                         reg_rd,
  input wire logic [31:0]                  reg_rd_data,
  // serial bus
  input wire logic                         bus_tx,
  input wire logic                         bus_tx_oe
);
  import codec_pkg::*;
  logic [12:0] cnt_ff;
  logic        par_ff;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // clock cycles since the word started
  always_ff @(posedge clk_sys) begin
    if (rst || !bus_tx_oe) cnt_ff <= 13'h0;
    else cnt_ff <= cnt_ff + 13'h1;
  end
  // first half of every bit cell after the sync
  always_ff @(posedge clk_sys) begin
    if (rst || !bus_tx_oe) par_ff <= 1'b0;
    else if (cnt_ff >= 13'h258 && cnt_ff % 13'hc8 == 13'h32) par_ff <= par_ff ^ bus_tx;
  end
  a_cmd_start:
    assert property (reg_wr && reg_addr == REG_CMD && !bus_tx_oe |=> bus_tx_oe && bus_tx)
    else $error("command word did not start high");
  a_data_start:
    assert property (reg_wr && reg_addr == REG_DATA && !bus_tx_oe |=> bus_tx_oe && !bus_tx)
    else $error("data word did not start low");
  a_sync_flip:
    assert property (bus_tx_oe && cnt_ff != 13'h0 && cnt_ff < 13'h258
      |-> (bus_tx != $past(bus_tx)) == (cnt_ff == 13'h12c))
    else $error("sync shape wrong");
  a_half_steady:
    assert property (bus_tx_oe && cnt_ff >= 13'h258 && cnt_ff % 13'h64 != 13'h0 |-> $stable(bus_tx))
    else $error("level moved inside a half bit");
  a_mid_edge:
    assert property (bus_tx_oe && cnt_ff >= 13'h258 && cnt_ff % 13'hc8 == 13'h64 |-> $changed(bus_tx))
    else $error("no mid-bit transition");
  a_word_len:
    assert property ($fell(bus_tx_oe) |-> cnt_ff == 13'hfa0)
    else $error("word length wrong");
  a_odd_parity:
    assert property ($fell(bus_tx_oe) |-> par_ff)
    else $error("word parity not odd");
  a_idle_low:
    assert property (!bus_tx_oe |-> !bus_tx)
    else $error("line driven while idle");
  a_rd_quiet:
    assert property (reg_rd_data != 32'h0 |-> $past(reg_rd))
    else $error("read data outside read slot");
endmodule : bus_controller_codec_monitor

bind bus_controller_codec bus_controller_codec_monitor monitor_inst (
  .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rd_data(reg_rd_data), .bus_tx(bus_tx), .bus_tx_oe(bus_tx_oe));

// File: tb/remote_terminal_model.sv
`timescale 1ns/10ps
module remote_terminal_model #(
  parameter logic [4:0] TERM_ADDR = 5'h05,
  parameter int         BCAST_BIT = 4
) (
  // serial bus
  input  wire logic        bus_tx,
  input  wire logic        bus_tx_oe,
  output logic             bus_rx,
  // fault control and capture
  input  wire logic        bad_par,
  output logic [15:0]      rx_info,
  output logic             rx_cmd,
  output logic             rx_ok
);
  logic [39:0] h;
  logic [15:0] info;
  logic        drv = 1'b0;
  logic        bcast_ff = 1'b0;
  initial begin
    bus_rx = 1'b0;
    rx_info = 16'h0;
    rx_cmd = 1'b0;
    rx_ok = 1'b0;
  end
  // released line shows no steady level
  always #7 if (!drv) bus_rx = ~bus_rx;
  task automatic send(input logic [16:0] w);
    drv = 1'b1;
    for (int i = 0; i < 6; i++) begin
      bus_rx = (i < 3);
      #500;
    end
    for (int i = 16; i >= 0; i--) begin
      bus_rx = w[i];
      #500;
      bus_rx = ~w[i];
      #500;
    end
    drv = 1'b0;
  endtask : send
  always begin
    @(posedge bus_tx_oe);
    #250;
    for (int i = 39; i >= 0; i--) begin
      h[i] = bus_tx;
      if (i > 0) #500;
    end
    rx_cmd = h[39];
    for (int i = 0; i < 16; i++) rx_info[15-i] = h[33-2*i];
    rx_ok = (h[39:34] == 6'h38 || h[39:34] == 6'h07) && ^{rx_info, h[1]};
    for (int i = 0; i < 17; i++) if (h[33-2*i] == h[32-2*i]) rx_ok = 1'b0;
    if (rx_ok && rx_cmd && rx_info[15:11] == 5'h1f) bcast_ff = 1'b1;
    else if (rx_ok && rx_cmd && rx_info[15:11] == TERM_ADDR) begin
      #4000;
      info = {TERM_ADDR, 11'h0};
      info[BCAST_BIT] = bcast_ff;
      send({info, ~^info ^ bad_par});
    end
  end
endmodule : remote_terminal_model

// File: tb/bus_controller_codec_tb.sv
`timescale 1ns/10ps
module bus_controller_codec_tb;
  import codec_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst, reg_wr, reg_rd, bus_rx, bus_tx, bus_tx_oe, bad_par, rx_cmd, rx_ok;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wr_data, reg_rd_data, v;
  logic [15:0] rx_info;
  logic [15:0] tbl [5];
  logic [31:0] exp_st [5];
  int          err_count = 0;
  int          checked = 0;
  always #2.5 clk_sys = ~clk_sys;
  bus_controller_codec bus_controller_codec_inst (.clk_sys(clk_sys), .rst(rst),
    .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rd_data(reg_rd_data), .bus_rx(bus_rx), .bus_tx(bus_tx), .bus_tx_oe(bus_tx_oe));
  remote_terminal_model remote_terminal_model_inst (.bus_tx(bus_tx), .bus_tx_oe(bus_tx_oe),
    .bus_rx(bus_rx), .bad_par(bad_par), .rx_info(rx_info), .rx_cmd(rx_cmd), .rx_ok(rx_ok));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wr_data <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(posedge clk_sys);
    d = reg_rd_data;
  endtask : rd
  task automatic wait_idle();
    for (int i = 0; i < 5000; i++) begin
      @(posedge clk_sys);
      if (bus_tx_oe === 1'b0) break;
    end
    chk({31'h0, bus_tx_oe}, 32'h0, "line idle in time");
  endtask : wait_idle
  task automatic wait_rx(output logic [31:0] s);
    for (int i = 0; i < 100; i++) begin
      rd(REG_STAT, s);
      if (s[2:1] !== 2'h0) break;
      repeat (98) @(posedge clk_sys);
    end
    chk({31'h0, s[2:1] !== 2'h0}, 32'h1, "reply received in time");
  endtask : wait_rx
  task automatic results();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results
  initial begin
    #400000;
    err_count++;
    results();
  end
  initial begin
    // addr, direction, subaddress, count
    tbl = '{{5'h1f, 1'b0, 5'h04, 5'h00}, {5'h07, 1'b1, 5'h00, 5'h02},
            {5'h07, 1'b0, 5'h1f, 5'h12}, {5'h07, 1'b0, 5'h01, 5'h1f},
            {5'h07, 1'b1, 5'h1e, 5'h01}};
    exp_st = '{32'h2021, 32'h00c1, 32'h01c1, 32'h1f81, 32'h0181};
    rst = 1'b1;
    reg_addr = 8'h0;
    reg_wr_data = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    bad_par = 1'b0;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rd(REG_STAT, v); chk(v, 32'h0, "status after reset");
    rd(REG_RX, v); chk(v, 32'h0, "rx after reset");
    wr(8'h10, 32'hffff_ffff);
    rd(8'h10, v); chk(v, 32'h0, "unmapped read");
    chk({31'h0, bus_tx_oe}, 32'h0, "unmapped write sent");
    $display("test reset done");
    foreach (tbl[k]) begin
      wr(REG_CMD, {3'h0, tbl[k][4:0], 3'h0, tbl[k][9:5], 7'h0, tbl[k][10], 3'h0, tbl[k][15:11]});
      rd(REG_STAT, v); chk(v & 32'h003f_3fe1, exp_st[k], "command decode");
      wait_idle();
      chk({16'h0, rx_info}, {16'h0, tbl[k]}, "command layout");
      chk({30'h0, rx_cmd, rx_ok}, 32'h3, "command sync and parity");
    end
    rd(REG_STAT, v); chk(v & 32'h2, 32'h0, "reply after broadcast");
    $display("test command words done");
    wr(REG_CMD, 32'h0305_0105);
    rd(REG_STAT, v); chk(v & 32'h003f_3fe1, 32'h0381, "addressed command");
    wr(REG_CMD, 32'h0);
    rd(REG_STAT, v); chk(v & 32'h11, 32'h11, "busy write refused");
    rd(REG_STAT, v); chk(v & 32'h10, 32'h0, "refused cleared by read");
    wait_idle();
    wait_rx(v); chk(v & 32'he, 32'ha, "status word received");
    rd(REG_RX, v); chk(v, 32'h2810, "status word content");
    rd(REG_STAT, v); chk(v & 32'h2, 32'h0, "rx valid cleared");
    $display("test response done");
    wr(REG_DATA, 32'h0000_a5c3);
    wait_idle();
    chk({16'h0, rx_info}, 32'ha5c3, "data word bits");
    chk({30'h0, rx_cmd, rx_ok}, 32'h1, "data sync and parity");
    $display("test data word done");
    bad_par <= 1'b1;
    wr(REG_CMD, 32'h0305_0105);
    wait_idle();
    wait_rx(v); chk(v & 32'h4, 32'h4, "parity error flagged");
    // second reply lands while the first is still unread
    wr(REG_CMD, 32'h0305_0105);
    wait_idle();
    repeat (5000) @(posedge clk_sys);
    rd(REG_STAT, v); chk(v & 32'h4000, 32'h4000, "overrun flagged");
    $display("test bad parity done");
    results();
  end
endmodule : bus_controller_codec_tb
